// ---- pfr_flags.sv ----
`timescale 1ns/1ps
// Contract
// - 32-bit word; bits 31:22,20:19,15,5,3 read zero, bit 1 reads one.
// - ident_support_flag writable only while config index E8h bit 7 is set.
// - alignment fault only when alignment check flag and mask bit both set.
// - virtual-8086 in protected mode: privileged opcodes raise exception 13.
// - virtual-8086 set only by return at level 0 or task switch; a bus write to the flags word also sets it at any level.
// - resume flag sampled at boundary suppresses debug fault on next instr.
// - nested task flag at bit 14 marks a nested protected-mode task.
// - I/O allowed without fault while privilege level within I/O field.
// - popped interrupt enable changes only if level within I/O field.
// - overflow set when carry into sign differs from carry out.
// - direction clear increments string indexes, set decrements them.
// - maskable interrupts acknowledged only while interrupt enable set.
// - trap flag causes single-step after next instruction, which clears it.
// - sign flag copies result msb.
// - zero flag set when result is zero.
// - aux carry set on carry out of or borrow into bit 3.
// - parity flag set when low byte holds even count of ones.
// - carry flag set on carry out of or borrow into msb.
// - low 16 bits form the legacy flags word for 16-bit code.
module pfr_flags
  import pfr_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // core side, same clock
  input wire logic alu_retire,
  input wire logic [3:0] alu_op,
  input wire logic [31:0] alu_a,
  input wire logic [31:0] alu_b,
  input wire logic instr_retire,
  input wire logic [2:0] flags_wr_src,
  input wire logic [31:0] flags_wr_data,
  input wire logic misaligned_access,
  input wire logic privileged_opcode,
  input wire logic io_instr,
  input wire logic debug_fault,
  input wire logic maskable_interrupt_input,
  output logic [31:0] processor_flags_word,
  output logic [31:0] alu_result,
  output logic alignment_fault,
  output logic gp_fault,
  output logic debug_fault_taken,
  output logic single_step_int,
  output logic interrupt_ack,
  output logic string_step_down
);

  typedef struct packed {
    logic [31:0] flags;
    logic [2:0] sys_ctrl;
    logic [7:0] cfg4;
    logic [1:0] priv_lvl;
    logic aw_got;
    logic w_got;
    logic [7:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic step_pending;
    logic rf_armed;
    logic [31:0] result;
    logic align_f;
    logic gp_f;
    logic dbg_f;
    logic step_int;
    logic int_ack;
  } pfr_state_t;

  pfr_state_t s_q;
  pfr_state_t s_d;

  // ==========================================================
  // flag update helpers
  function automatic logic [31:0] pfr_sanitize(input logic [31:0] v);
    return (v & PFR_WMASK) | PFR_FIXED1;
  endfunction : pfr_sanitize

  logic [32:0] sum_w;
  logic [4:0] nib_w;
  logic [31:0] res_w;
  logic c_out_w;
  logic c_in_sign_w;
  logic [31:0] pop_w;
  logic [31:0] wr_mask_w;
  // level within the i/o field gates both i/o access and popped enable
  logic lvl_ok_w;
  logic [31:0] axi_wval_w;
  logic [31:0] rd_mux_w;
  logic wr_fire_w;

  always_comb begin
    s_d = s_q;
    sum_w = '0;
    nib_w = '0;
    res_w = '0;
    c_out_w = 1'b0;
    c_in_sign_w = 1'b0;
    lvl_ok_w = s_q.priv_lvl <= s_q.flags[PFR_IOPRIV_LO +: 2];

    // ========================================================
    // arithmetic datapath
    unique case (pfr_op_t'(alu_op))
      PFR_OP_ADD: begin
        sum_w = {1'b0, alu_a} + {1'b0, alu_b};
        nib_w = {1'b0, alu_a[3:0]} + {1'b0, alu_b[3:0]};
        c_in_sign_w = alu_a[31] ^ alu_b[31] ^ sum_w[31];
      end
      PFR_OP_SUB: begin
        sum_w = {1'b0, alu_a} - {1'b0, alu_b};
        nib_w = {1'b0, alu_a[3:0]} - {1'b0, alu_b[3:0]};
        c_in_sign_w = alu_a[31] ^ alu_b[31] ^ sum_w[31];
      end
      // logic ops leave carry, overflow and aux carry cleared
      PFR_OP_AND: begin
        sum_w = {1'b0, alu_a & alu_b};
      end
      PFR_OP_OR: begin
        sum_w = {1'b0, alu_a | alu_b};
      end
      PFR_OP_XOR: begin
        sum_w = {1'b0, alu_a ^ alu_b};
      end
      default: begin
        sum_w = {1'b0, alu_a};
      end
    endcase
    res_w = sum_w[31:0];
    c_out_w = sum_w[32];

    if (alu_retire) begin
      s_d.result = res_w;
      // flags register with alu_result at the end of the retire cycle, no bypass needed downstream
      s_d.flags[PFR_CARRY] = c_out_w;
      s_d.flags[PFR_OVF] = c_in_sign_w ^ c_out_w;
      s_d.flags[PFR_SIGN] = res_w[31];
      s_d.flags[PFR_ZERO] = (res_w == 32'h0);
      s_d.flags[PFR_AUXC] = nib_w[4];
      s_d.flags[PFR_PARITY] = ~^res_w[7:0];
    end

    // ========================================================
    // whole-word loads: pop or task switch
    pop_w = flags_wr_data;
    wr_mask_w = PFR_WMASK;
    if (!s_q.cfg4[PFR_IDENT_EN_BIT]) begin
      wr_mask_w[PFR_IDENT] = 1'b0;
    end
    unique case (pfr_src_t'(flags_wr_src))
      PFR_WR_POP: begin
        if (!lvl_ok_w) begin
          pop_w[PFR_INTEN] = s_q.flags[PFR_INTEN];
        end
        if (s_q.priv_lvl != 2'h0) begin
          pop_w[PFR_V86] = s_q.flags[PFR_V86];
        end
        if (s_q.sys_ctrl[PFR_CTRL_OP16]) begin
          // 16-bit code sees only the legacy half
          pop_w[31:16] = s_q.flags[31:16];
        end
        s_d.flags = pfr_sanitize((s_q.flags & ~wr_mask_w) |
                                 (pop_w & wr_mask_w));
      end
      PFR_WR_TASK: begin
        // the nesting bit and all other writable bits come from the new task state, ident only while cfg4 bit 7 is set
        s_d.flags = pfr_sanitize((s_q.flags & ~wr_mask_w) |
                                 (pop_w & wr_mask_w));
      end
      default: ;
    endcase

    // ========================================================
    // debug, interrupt and fault events; step and resume update at retire
    s_d.step_int = 1'b0;
    s_d.dbg_f = 1'b0;
    if (instr_retire) begin
      s_d.step_int = s_q.step_pending;
      s_d.step_pending = s_q.flags[PFR_TRAP];
      if (s_q.step_pending) begin
        s_d.flags[PFR_TRAP] = 1'b0;
        s_d.step_pending = 1'b0;
      end
      // resume covers exactly one instruction, so it is consumed here
      s_d.rf_armed = s_q.flags[PFR_RESUME];
      s_d.flags[PFR_RESUME] = 1'b0;
    end
    s_d.dbg_f = debug_fault & ~s_q.rf_armed;
    s_d.int_ack = maskable_interrupt_input & s_q.flags[PFR_INTEN];
    s_d.align_f = misaligned_access & s_q.flags[PFR_ALIGN] &
                  s_q.sys_ctrl[PFR_CTRL_AMASK];
    s_d.gp_f = s_q.sys_ctrl[PFR_CTRL_PE] &
               ((privileged_opcode & s_q.flags[PFR_V86]) |
                (io_instr & ~lvl_ok_w));

    // ========================================================
    // axi4-lite write
    if (s_q.awready && s_axi_awvalid) begin
      s_d.aw_got = 1'b1;
      s_d.awaddr = s_axi_awaddr;
    end
    if (s_q.wready && s_axi_wvalid) begin
      s_d.w_got = 1'b1;
      s_d.wdata = s_axi_wdata;
      s_d.wstrb = s_axi_wstrb;
    end
    s_d.awready = !s_d.aw_got && !s_q.bvalid;
    s_d.wready = !s_d.w_got && !s_q.bvalid;
    wr_fire_w = s_q.aw_got && s_q.w_got && !s_q.bvalid;
    axi_wval_w = s_q.flags;
    for (int i = 0; i < 4; i++) begin
      if (s_q.wstrb[i]) begin
        axi_wval_w[i*8 +: 8] = s_q.wdata[i*8 +: 8];
      end
    end
    if (wr_fire_w) begin
      s_d.aw_got = 1'b0;
      s_d.w_got = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp = AXI_OKAY;
      unique case (s_q.awaddr)
        PFR_ADDR_FLAGS: begin
          s_d.flags = pfr_sanitize((s_d.flags & ~wr_mask_w) |
                                   (axi_wval_w & wr_mask_w));
        end
        PFR_ADDR_CTRL: begin
          if (s_q.wstrb[0]) begin
            s_d.sys_ctrl = s_q.wdata[2:0];
          end
        end
        PFR_ADDR_CFG4: begin
          if (s_q.wstrb[0]) begin
            s_d.cfg4 = s_q.wdata[7:0];
          end
        end
        PFR_ADDR_PRIV: begin
          if (s_q.wstrb[0]) begin
            s_d.priv_lvl = s_q.wdata[1:0];
          end
        end
        default: s_d.bresp = AXI_SLVERR;
      endcase
    end
    if (s_q.bvalid && s_axi_bready) begin
      s_d.bvalid = 1'b0;
      s_d.awready = !s_d.aw_got;
      s_d.wready = !s_d.w_got;
    end

    // ========================================================
    // axi4-lite read
    unique case (s_axi_araddr)
      PFR_ADDR_FLAGS: begin
        rd_mux_w = pfr_sanitize(s_q.flags);
      end
      PFR_ADDR_CTRL: begin
        rd_mux_w = {29'h0, s_q.sys_ctrl};
      end
      PFR_ADDR_CFG4: begin
        rd_mux_w = {24'h0, s_q.cfg4};
      end
      PFR_ADDR_PRIV: begin
        rd_mux_w = {30'h0, s_q.priv_lvl};
      end
      default: begin
        // unmapped reads return zero beside the error response
        rd_mux_w = 32'h0;
      end
    endcase
    if (s_q.arready && s_axi_arvalid) begin
      s_d.arready = 1'b0;
      s_d.rvalid = 1'b1;
      s_d.rdata = rd_mux_w;
      s_d.rresp = (s_axi_araddr[7:4] == 4'h0 && s_axi_araddr[1:0] == 2'h0)
                  ? AXI_OKAY : AXI_SLVERR;
    end
    if (s_q.rvalid && s_axi_rready) begin
      s_d.rvalid = 1'b0;
      s_d.arready = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= '0;
      s_q.flags <= PFR_RESET;
      s_q.awready <= 1'b1;
      s_q.wready <= 1'b1;
      s_q.arready <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // ==========================================================
  // outputs
  assign s_axi_awready = s_q.awready;
  assign s_axi_wready = s_q.wready;
  assign s_axi_bvalid = s_q.bvalid;
  assign s_axi_bresp = s_q.bresp;
  assign s_axi_arready = s_q.arready;
  assign s_axi_rvalid = s_q.rvalid;
  assign s_axi_rdata = s_q.rdata;
  assign s_axi_rresp = s_q.rresp;
  assign processor_flags_word = s_q.flags;
  assign alu_result = s_q.result;
  assign alignment_fault = s_q.align_f;
  assign gp_fault = s_q.gp_f;
  assign debug_fault_taken = s_q.dbg_f;
  assign single_step_int = s_q.step_int;
  assign interrupt_ack = s_q.int_ack;
  assign string_step_down = s_q.flags[PFR_DIR];

endmodule : pfr_flags

// ---- pfr_pkg.sv ----
package pfr_pkg;

  // ==========================================================
  // flags word layout
  localparam int PFR_CARRY = 0;
  localparam int PFR_ONE = 1;
  localparam int PFR_PARITY = 2;
  localparam int PFR_AUXC = 4;
  localparam int PFR_ZERO = 6;
  localparam int PFR_SIGN = 7;
  localparam int PFR_TRAP = 8;
  localparam int PFR_INTEN = 9;
  localparam int PFR_DIR = 10;
  localparam int PFR_OVF = 11;
  localparam int PFR_IOPRIV_LO = 12;
  localparam int PFR_NEST = 14;
  localparam int PFR_RESUME = 16;
  localparam int PFR_V86 = 17;
  localparam int PFR_ALIGN = 18;
  localparam int PFR_IDENT = 21;
  localparam int PFR_IDENT_EN_BIT = 7;
  localparam logic [7:0] PFR_CFG4_INDEX = 8'hE8;

  // writable bits; everything else is fixed
  localparam logic [31:0] PFR_WMASK = 32'h00277FD5;
  localparam logic [31:0] PFR_FIXED1 = 32'h00000002;
  localparam logic [31:0] PFR_RESET = 32'h00000002;

  // ==========================================================
  // register map
  localparam logic [7:0] PFR_ADDR_FLAGS = 8'h00;
  localparam logic [7:0] PFR_ADDR_CTRL = 8'h04;
  localparam logic [7:0] PFR_ADDR_CFG4 = 8'h08;
  localparam logic [7:0] PFR_ADDR_PRIV = 8'h0C;
  localparam int PFR_CTRL_PE = 0;
  localparam int PFR_CTRL_AMASK = 1;
  localparam int PFR_CTRL_OP16 = 2;

  // ==========================================================
  // datapath
  typedef enum logic [3:0] {
    PFR_OP_ADD = 4'h0,
    PFR_OP_SUB = 4'h1,
    PFR_OP_AND = 4'h2,
    PFR_OP_OR = 4'h3,
    PFR_OP_XOR = 4'h4,
    PFR_OP_PASS = 4'h5
  } pfr_op_t;

  typedef enum logic [2:0] {
    PFR_WR_NONE = 3'b001,
    PFR_WR_POP = 3'b010,
    PFR_WR_TASK = 3'b100
  } pfr_src_t;

  localparam logic [1:0] AXI_OKAY = 2'h0;
  localparam logic [1:0] AXI_SLVERR = 2'h2;

endpackage : pfr_pkg

// ---- pfr_flags_assertions.sv ----
`timescale 1ns/1ps
module pfr_flags_chk
  import pfr_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awready,
  input wire logic s_axi_wready,
  input wire logic alu_retire,
  input wire logic [3:0] alu_op,
  input wire logic [31:0] alu_a,
  input wire logic [31:0] alu_b,
  input wire logic instr_retire,
  input wire logic [2:0] flags_wr_src,
  input wire logic misaligned_access,
  input wire logic debug_fault,
  input wire logic maskable_interrupt_input,
  input wire logic [31:0] processor_flags_word,
  input wire logic [31:0] alu_result,
  input wire logic alignment_fault,
  input wire logic debug_fault_taken,
  input wire logic single_step_int,
  input wire logic interrupt_ack,
  input wire logic string_step_down
);
  logic [32:0] sum;
  logic ovf;
  assign sum = {1'b0, alu_a} + {1'b0, alu_b};
  assign ovf = (alu_a[31] == alu_b[31]) && (sum[31] != alu_a[31]);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ==========================================================
  // fixed bits and arithmetic flags
  // a bus write or pop outranks the alu, so only lone retires count
  sequence alu_only_s;
    alu_retire && flags_wr_src == PFR_WR_NONE && s_axi_awready && s_axi_wready;
  endsequence
  sequence add_s;
    alu_only_s ##0 alu_op == PFR_OP_ADD;
  endsequence
  fixed_bits_a: assert property (
    (processor_flags_word & ~PFR_WMASK) == PFR_FIXED1)
    else $error("fixed bits");
  sign_zero_a: assert property (alu_only_s |=>
    processor_flags_word[PFR_SIGN] == alu_result[31] &&
    processor_flags_word[PFR_ZERO] == (alu_result == 32'h0))
    else $error("sign zero");
  parity_a: assert property (alu_only_s |=>
    processor_flags_word[PFR_PARITY] == ~^alu_result[7:0])
    else $error("parity");
  add_carry_a: assert property (add_s |=>
    processor_flags_word[PFR_CARRY] == $past(sum[32]) &&
    processor_flags_word[PFR_OVF] == $past(ovf)) else $error("carry overflow");
  // ==========================================================
  // system and debug flags
  align_fault_a: assert property (alignment_fault |->
    $past(misaligned_access && processor_flags_word[PFR_ALIGN]))
    else $error("align");
  maskable_interrupt_input_ack_a: assert property (interrupt_ack ==
    $past(maskable_interrupt_input && processor_flags_word[PFR_INTEN]))
    else $error("ack");
  step_down_a: assert property (
    string_step_down == processor_flags_word[PFR_DIR])
    else $error("direction");
  step_clear_a: assert property (single_step_int |->
    !processor_flags_word[PFR_TRAP] && $past(instr_retire))
    else $error("step");
  debug_mask_a: assert property (
    debug_fault_taken |-> $past(debug_fault)) else $error("debug");
endmodule : pfr_flags_chk

bind pfr_flags pfr_flags_chk u_pfr_flags_chk (.*);

// ---- test_processor_flags_register.sv ----
`timescale 1ns/1ps
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin bad_count++; \
  $display("wrong value %s exp %h seen %h", n, e, g); end end
module test_processor_flags_register
  import pfr_pkg::*;
;
  logic aclk = 0;
  logic aresetn = 0;
  logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0, alu_retire = 0;
  logic [31:0] s_axi_wdata = 0, alu_a = 0, alu_b = 0, flags_wr_data = 0;
  logic [3:0] s_axi_wstrb = 4'hF, alu_op = 0;
  logic instr_retire = 0, misaligned_access = 0, privileged_opcode = 0;
  logic io_instr = 0, debug_fault = 0, maskable_interrupt_input = 0;
  logic [2:0] flags_wr_src = PFR_WR_NONE;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, alignment_fault, gp_fault, debug_fault_taken;
  logic single_step_int, interrupt_ack, string_step_down, seen;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  logic [31:0] s_axi_rdata, processor_flags_word, alu_result, rd;
  logic [11:0] fw;
  int bad_count = 0, tests_run = 0, cyc = 0;
  typedef struct {
    logic [3:0] op; logic [31:0] a, b, res; logic [11:0] fl, mk;
  } pfr_row_t;
  // logic ops leave carry, overflow and aux carry to the mask
  pfr_row_t rows [8] = '{
    '{PFR_OP_ADD, 32'h7FFFFFFF, 32'h1, 32'h80000000, 12'h894, 12'h8D5},
    '{PFR_OP_ADD, 32'hFFFFFFFF, 32'h1, 32'h0, 12'h055, 12'h8D5},
    '{PFR_OP_SUB, 32'h0, 32'h1, 32'hFFFFFFFF, 12'h095, 12'h8D5},
    '{PFR_OP_SUB, 32'h80000000, 32'h1, 32'h7FFFFFFF, 12'h814, 12'h8D5},
    '{PFR_OP_AND, 32'hF0, 32'h3C, 32'h30, 12'h004, 12'h0C4},
    '{PFR_OP_OR, 32'h0, 32'h0, 32'h0, 12'h044, 12'h0C4},
    '{PFR_OP_XOR, 32'h80000001, 32'h0, 32'h80000001, 12'h080, 12'h0C4},
    '{PFR_OP_PASS, 32'h3, 32'h0, 32'h3, 12'h004, 12'h0C4}};

  pfr_flags u_pfr_flags (.*);
  always #2.5 aclk = ~aclk;

  task tally_and_finish;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : tally_and_finish

  // run should need well under a thousand cycles
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 4000) begin
      bad_count++;
      tally_and_finish;
    end
  end

  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    rs = s_axi_bresp;
  endtask : wr

  task rdr(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    rd = s_axi_rdata;
    rs = s_axi_rresp;
  endtask : rdr

  task pop(input logic [2:0] s, input logic [31:0] d);
    @(posedge aclk);
    flags_wr_src <= s;
    flags_wr_data <= d;
    @(posedge aclk);
    flags_wr_src <= PFR_WR_NONE;
    @(posedge aclk);
  endtask : pop

  task edges2;
    repeat (2) @(posedge aclk);
  endtask : edges2

  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    foreach (rows[i]) begin
      @(posedge aclk);
      alu_retire <= 1'b1;
      alu_op <= rows[i].op;
      alu_a <= rows[i].a;
      alu_b <= rows[i].b;
      @(posedge aclk);
      alu_retire <= 1'b0;
      @(posedge aclk);
      `CHK("result", rows[i].res, alu_result)
      fw = processor_flags_word[11:0] & rows[i].mk;
      `CHK("fl", rows[i].fl, fw)
    end
    $display("end alu rows");
    wr(PFR_ADDR_FLAGS, 32'hFFFFFFFF);
    `CHK("gated word", 32'h00077FD7, processor_flags_word)
    `CHK("step down", 1'b1, string_step_down)
    maskable_interrupt_input <= 1'b1;
    edges2;
    `CHK("ack", 1'b1, interrupt_ack)
    wr(PFR_ADDR_CFG4, 32'h80);
    wr(PFR_ADDR_FLAGS, 32'h00200002);
    edges2;
    `CHK("ack masked", 1'b0, interrupt_ack)
    maskable_interrupt_input <= 1'b0;
    rdr(PFR_ADDR_FLAGS);
    `CHK("ident word", 32'h00200002, rd)
    rdr(8'h10);
    `CHK("unmapped", AXI_SLVERR, rs)
    $display("end bus");
    aresetn <= 1'b0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    `CHK("reset", PFR_RESET, processor_flags_word)
    $display("end reset");
    wr(PFR_ADDR_CTRL, 32'h2);
    wr(PFR_ADDR_FLAGS, 32'h00040002);
    misaligned_access <= 1'b1;
    edges2;
    `CHK("align", 1'b1, alignment_fault)
    wr(PFR_ADDR_CTRL, 32'h0);
    edges2;
    `CHK("align off", 1'b0, alignment_fault)
    misaligned_access <= 1'b0;
    wr(PFR_ADDR_FLAGS, 32'h102);
    repeat (2) begin
      @(posedge aclk);
      instr_retire <= 1'b1;
      @(posedge aclk);
      instr_retire <= 1'b0;
    end
    seen = 1'b0;
    repeat (3) begin
      @(posedge aclk);
      seen = seen | single_step_int;
    end
    `CHK("single step", 1'b1, seen)
    `CHK("trap", 1'b0, processor_flags_word[PFR_TRAP])
    $display("end debug");
    wr(PFR_ADDR_PRIV, 32'h3);
    pop(PFR_WR_POP, 32'h00020202);
    `CHK("pop lvl3", 32'h2, processor_flags_word)
    wr(PFR_ADDR_PRIV, 32'h0);
    pop(PFR_WR_POP, 32'h00020202);
    `CHK("pop lvl0", 32'h00020202, processor_flags_word)
    wr(PFR_ADDR_PRIV, 32'h3);
    pop(PFR_WR_TASK, 32'h00020002);
    `CHK("task", 32'h00020002, processor_flags_word)
    wr(PFR_ADDR_CTRL, 32'h4);
    wr(PFR_ADDR_PRIV, 32'h0);
    pop(PFR_WR_POP, 32'h00000044);
    `CHK("pop 16", 32'h00020046, processor_flags_word)
    $display("end pop");
    wr(PFR_ADDR_CTRL, 32'h1);
    privileged_opcode <= 1'b1;
    edges2;
    `CHK("gp v86", 1'b1, gp_fault)
    privileged_opcode <= 1'b0;
    wr(PFR_ADDR_PRIV, 32'h3);
    io_instr <= 1'b1;
    edges2;
    `CHK("gp io", 1'b1, gp_fault)
    wr(PFR_ADDR_FLAGS, 32'h00003002);
    edges2;
    `CHK("io allowed", 1'b0, gp_fault)
    io_instr <= 1'b0;
    wr(PFR_ADDR_FLAGS, 32'h00013002);
    debug_fault <= 1'b1;
    edges2;
    `CHK("debug", 1'b1, debug_fault_taken)
    @(posedge aclk);
    instr_retire <= 1'b1;
    @(posedge aclk);
    instr_retire <= 1'b0;
    edges2;
    `CHK("debug resumed", 1'b0, debug_fault_taken)
    `CHK("resume clear", 1'b0, processor_flags_word[PFR_RESUME])
    debug_fault <= 1'b0;
    $display("end faults");
    tally_and_finish;
  end
endmodule : test_processor_flags_register
